// ==== hw/fpr_pkg.sv ====
// Constants, types and register map of the flash protection block
package fpr_pkg;

  // ==========================================================
  // Register map (AXI4-Lite byte addresses)
  localparam logic [3:0] FPR_OFS_PGM = 4'h0;
  localparam logic [3:0] FPR_OFS_DATA = 4'h4;
  localparam logic [3:0] FPR_OFS_STAT = 4'h8;
  localparam logic [1:0] FPR_RESP_OKAY = 2'h0;
  localparam logic [1:0] FPR_RESP_SLVERR = 2'h2;

  // ==========================================================
  // Program-flash protection fields
  localparam int FPR_P_OPEN = 7;
  localparam int FPR_P_RNV = 6;
  localparam int FPR_P_HDIS = 5;
  localparam int FPR_P_HS_HI = 4;
  localparam int FPR_P_HS_LO = 3;
  localparam int FPR_P_LDIS = 2;
  localparam int FPR_P_LS_HI = 1;
  localparam int FPR_P_LS_LO = 0;
  localparam logic [7:0] FPR_PGM_FULL = 8'h7f;
  localparam logic [2:0] FPR_SCEN_NONE = 3'h7;

  // ==========================================================
  // Data-flash protection fields
  localparam int FPR_D_EN_N = 7;
  localparam int FPR_D_SIZE_HI = 3;
  localparam logic [7:0] FPR_DATA_MASK = 8'h8f;
  localparam logic [7:0] FPR_DATA_FULL = 8'h0f;

  // ==========================================================
  // Status register fields
  localparam int FPR_S_VIOL = 0;
  localparam int FPR_S_LOADED = 1;

  // ==========================================================
  // Address windows
  localparam logic [17:0] FPR_PGM_TOP = 18'h3_ffff;
  localparam logic [17:0] FPR_HI_START [4] = '{18'h3_f800, 18'h3_f000, 18'h3_e000, 18'h3_c000};
  localparam logic [17:0] FPR_LO_BASE = 18'h3_8000;
  localparam logic [17:0] FPR_LO_END [4] = '{18'h3_83ff, 18'h3_87ff, 18'h3_8fff, 18'h3_9fff};
  localparam logic [17:0] FPR_DATA_BASE = 18'h0_4400;
  localparam logic [7:0] FPR_DATA_STEP_LOW = 8'hff;
  localparam logic [17:0] FPR_CFG_PGM_ADDR = 18'h3_ff0c;
  localparam logic [17:0] FPR_CFG_DATA_ADDR = 18'h3_ff0d;

  // ==========================================================
  // Allowed scenario transitions, one row per source, bit per target
  localparam logic [7:0] FPR_TRANS [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};

  // ==========================================================
  // Types
  typedef enum logic [1:0] {FPR_OP_PROGRAM, FPR_OP_SECTOR_ERASE, FPR_OP_BLOCK_ERASE} fpr_op_e;

  typedef struct packed {
    logic [7:0] pgm_byte;
    logic [7:0] data_byte;
    logic pgm_dbf;
    logic data_dbf;
  } fpr_cfg_s;

  typedef struct packed {
    logic is_data;
    fpr_op_e op;
    logic [17:0] addr;
  } fpr_cmd_s;

endpackage : fpr_pkg

// ==== hw/fpr_flash_protection.sv ====
// Flash protection registers, window decode and command check
// Operation
// [RULE1] Bit 5 disables top program window
// [RULE2] High size writable only while disabled
// [RULE3] High size code picks window start
// [RULE4] Bit 2 disables bottom program window
// [RULE5] Low size writable only while disabled
// [RULE6] Low size code picks window end
// [RULE7] Enable one: windows protected, rest writable
// [RULE8] Enable zero: windows unprotected, rest protected
// [RULE9] Program register loaded from configuration at reset
// [RULE10] Illegal scenario write discarded whole
// [RULE11] Scenario transition table limits changes
// [RULE12] Read returns scenario in force
// [RULE13] Data register only grows, enable one-way
// [RULE14] Data enable bit set means unprotected
// [RULE15] Data register loaded from configuration at reset
// [RULE16] Data fault at load gives full protection
// [RULE17] Protected data command flags violation
// [RULE18] Data block erase refused if protected
// [RULE19] Data size field sets protected size
// [RULE20] Software reprograms configuration byte after unprotecting
// [RULE21] Data window from base, 256 bytes step
// [RULE22] Program fault at load gives full protection
// [RULE23] Protected program command flags violation
// [RULE24] Check uses protection state at command start
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module fpr_flash_protection
  import fpr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cfg_load_valid,
  input wire fpr_cfg_s cfg_load,
  input wire logic cmd_valid,
  input wire fpr_cmd_s cmd,
  output logic chk_done,
  output logic chk_violation,
  output logic protection_violation_flag
);

  // ==========================================================
  // Decode functions
  function automatic logic fpr_pgm_hit(input logic [7:0] r, input logic [17:0] a);
    logic hi;
    logic lo;
    hi = !r[FPR_P_HDIS] && a >= FPR_HI_START[r[FPR_P_HS_HI:FPR_P_HS_LO]]
         && a <= FPR_PGM_TOP; // [RULE1] [RULE3]
    lo = !r[FPR_P_LDIS] && a >= FPR_LO_BASE
         && a <= FPR_LO_END[r[FPR_P_LS_HI:FPR_P_LS_LO]]; // [RULE4] [RULE6]
    return r[FPR_P_OPEN] ? (hi || lo) : !(hi || lo); // [RULE7] [RULE8]
  endfunction : fpr_pgm_hit

  function automatic logic fpr_data_hit(input logic [7:0] r, input logic [17:0] a);
    logic [17:0] last;
    last = FPR_DATA_BASE + {6'h0, r[FPR_D_SIZE_HI:0], FPR_DATA_STEP_LOW}; // [RULE19] [RULE21]
    return !r[FPR_D_EN_N] && a >= FPR_DATA_BASE && a <= last; // [RULE14]
  endfunction : fpr_data_hit

  function automatic logic [2:0] fpr_scen(input logic [7:0] r);
    return {r[FPR_P_OPEN], r[FPR_P_HDIS], r[FPR_P_LDIS]};
  endfunction : fpr_scen

  // ==========================================================
  // Registers
  logic [7:0] pgm_q;
  logic [7:0] data_q;
  logic loaded_q;
  logic aw_have_q;
  logic w_have_q;
  logic [3:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic wr_fire;
  logic load_fire;
  logic [7:0] pgm_d;
  logic pgm_ok;
  logic [7:0] data_d;
  logic data_ok;
  logic cmd_hit;

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign load_fire = cfg_load_valid && !loaded_q;

  // Size fields only take new data while their window is off
  always_comb
  begin
    pgm_d = pgm_q;
    pgm_d[FPR_P_OPEN] = wbyte_q[FPR_P_OPEN];
    pgm_d[FPR_P_HDIS] = wbyte_q[FPR_P_HDIS];
    pgm_d[FPR_P_LDIS] = wbyte_q[FPR_P_LDIS];
    if (pgm_q[FPR_P_HDIS])
    begin
      pgm_d[FPR_P_HS_HI:FPR_P_HS_LO] = wbyte_q[FPR_P_HS_HI:FPR_P_HS_LO]; // [RULE2]
    end
    if (pgm_q[FPR_P_LDIS])
    begin
      pgm_d[FPR_P_LS_HI:FPR_P_LS_LO] = wbyte_q[FPR_P_LS_HI:FPR_P_LS_LO]; // [RULE5]
    end
    pgm_ok = FPR_TRANS[fpr_scen(pgm_q)][fpr_scen(pgm_d)]; // [RULE11]
  end

  // Data protection may only grow; enable bit only drops
  always_comb
  begin
    data_d = wbyte_q & FPR_DATA_MASK;
    data_ok = !(data_d[FPR_D_EN_N] && !data_q[FPR_D_EN_N])
              && ((data_d[FPR_D_SIZE_HI:0] > data_q[FPR_D_SIZE_HI:0])
              || (data_d[FPR_D_SIZE_HI:0] == data_q[FPR_D_SIZE_HI:0]
              && data_q[FPR_D_EN_N] && !data_d[FPR_D_EN_N])); // [RULE13]
  end

  // Program-flash protection register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pgm_q <= FPR_PGM_FULL;
    end
    else if (load_fire)
    begin
      pgm_q <= cfg_load.pgm_dbf ? FPR_PGM_FULL : cfg_load.pgm_byte; // [RULE9] [RULE22]
    end
    else if (wr_fire && loaded_q && wlane_q && awaddr_q == FPR_OFS_PGM && pgm_ok)
    begin
      pgm_q <= pgm_d; // [RULE10]
    end
  end

  // Data-flash protection register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      data_q <= FPR_DATA_FULL;
    end
    else if (load_fire)
    begin
      data_q <= cfg_load.data_dbf ? FPR_DATA_FULL
                : (cfg_load.data_byte & FPR_DATA_MASK); // [RULE15] [RULE16]
    end
    else if (wr_fire && loaded_q && wlane_q && awaddr_q == FPR_OFS_DATA && data_ok)
    begin
      data_q <= data_d; // [RULE13]
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      loaded_q <= 1'b0;
    end
    else if (load_fire)
    begin
      loaded_q <= 1'b1;
    end
  end

  // ==========================================================
  // Command check
  always_comb
  begin
    if (cmd.op == FPR_OP_BLOCK_ERASE)
    begin
      cmd_hit = cmd.is_data ? !data_q[FPR_D_EN_N]
                : (fpr_scen(pgm_q) != FPR_SCEN_NONE); // [RULE18] [RULE23]
    end
    else
    begin
      cmd_hit = cmd.is_data ? fpr_data_hit(data_q, cmd.addr)
                : fpr_pgm_hit(pgm_q, cmd.addr); // [RULE17] [RULE23] [RULE24]
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      chk_done <= 1'b0;
      chk_violation <= 1'b0;
    end
    else
    begin
      chk_done <= cmd_valid;
      chk_violation <= cmd_valid && cmd_hit;
    end
  end

  // Sticky flag; a new hit wins over a clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      protection_violation_flag <= 1'b0;
    end
    else if (cmd_valid && cmd_hit)
    begin
      protection_violation_flag <= 1'b1; // [RULE17]
    end
    else if (wr_fire && wlane_q && awaddr_q == FPR_OFS_STAT && wbyte_q[FPR_S_VIOL])
    begin
      protection_violation_flag <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      awaddr_q <= 4'h0;
      s_axi_awready <= 1'b1;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (wr_fire)
    begin
      aw_have_q <= 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_q <= 1'b0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      s_axi_wready <= 1'b1;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_q <= 1'b1;
      wbyte_q <= s_axi_wdata[7:0];
      wlane_q <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end
    else if (wr_fire)
    begin
      w_have_q <= 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= FPR_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_q == FPR_OFS_PGM || awaddr_q == FPR_OFS_DATA
                      || awaddr_q == FPR_OFS_STAT) ? FPR_RESP_OKAY : FPR_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= FPR_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= FPR_RESP_OKAY;
      unique case (s_axi_araddr)
        FPR_OFS_PGM: s_axi_rdata <= {24'h00_0000, pgm_q}; // [RULE12]
        FPR_OFS_DATA: s_axi_rdata <= {24'h00_0000, data_q};
        FPR_OFS_STAT: s_axi_rdata <= {30'h0000_0000, loaded_q, protection_violation_flag};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= FPR_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_PGM_TRANS: assert property ($changed(pgm_q) && !$past(load_fire)
    |-> FPR_TRANS[fpr_scen($past(pgm_q))][fpr_scen(pgm_q)]) // [RULE10] [RULE11]
    else $error("Illegal program protection transition");
  AST_HI_SIZE_LOCK: assert property (!pgm_q[FPR_P_HDIS] && !load_fire
    |=> $stable(pgm_q[FPR_P_HS_HI:FPR_P_HS_LO])) // [RULE2]
    else $error("High size changed while window enabled");
  AST_LO_SIZE_LOCK: assert property (!pgm_q[FPR_P_LDIS] && !load_fire
    |=> $stable(pgm_q[FPR_P_LS_HI:FPR_P_LS_LO])) // [RULE5]
    else $error("Low size changed while window enabled");
  AST_DATA_EN_ONEWAY: assert property (!data_q[FPR_D_EN_N] && !load_fire
    |=> !data_q[FPR_D_EN_N]) // [RULE13]
    else $error("Data protection enable reopened");
  AST_DATA_GROW: assert property ($changed(data_q[FPR_D_SIZE_HI:0]) && !$past(load_fire)
    |-> data_q[FPR_D_SIZE_HI:0] > $past(data_q[FPR_D_SIZE_HI:0])) // [RULE13]
    else $error("Data protection size shrank");
  AST_PGM_DBF: assert property (load_fire && cfg_load.pgm_dbf
    |=> pgm_q == FPR_PGM_FULL) // [RULE22]
    else $error("Program fault load not fully protected");
  AST_DATA_DBF: assert property (load_fire && cfg_load.data_dbf
    |=> data_q == FPR_DATA_FULL) // [RULE16]
    else $error("Data fault load not fully protected");
  AST_VIOL_SET: assert property (cmd_valid && cmd_hit
    |=> chk_done && chk_violation && protection_violation_flag) // [RULE17] [RULE23]
    else $error("Violation not flagged");
  AST_DATA_OFF: assert property (cmd_valid && cmd.is_data && data_q[FPR_D_EN_N]
    |=> !chk_violation) // [RULE14]
    else $error("Data protection active while disabled");
  AST_NO_PROT_ALL_OPEN: assert property (cmd_valid && !cmd.is_data
    && fpr_scen(pgm_q) == FPR_SCEN_NONE |=> chk_done && !chk_violation) // [RULE7]
    else $error("Program command refused with no protection");
  AST_PGM_READ: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == FPR_OFS_PGM
    |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(pgm_q)) // [RULE12]
    else $error("Program register readback wrong");

  COV_LOAD_DBF: cover property (load_fire && cfg_load.pgm_dbf);
  COV_PGM_UPGRADE: cover property ($changed(pgm_q) && !$past(load_fire));
  COV_DATA_VIOL: cover property (cmd_valid && cmd.is_data && cmd_hit);
  COV_BLOCK_REFUSED: cover property (cmd_valid && cmd.op == FPR_OP_BLOCK_ERASE && cmd_hit);

endmodule : fpr_flash_protection

// ==== sim/fpr_flash_protection_tb.sv ====
// Self-checking bench for the flash protection block
`timescale 1ns/1ps
module fpr_flash_protection_tb;
  import fpr_pkg::*;
  // ========================================
  // Expectation tables and signals
  localparam logic [7:0] TR [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};
  localparam logic [17:0] HI [4] = '{18'h3_f800, 18'h3_f000, 18'h3_e000, 18'h3_c000};
  localparam logic [17:0] LO [4] = '{18'h3_83ff, 18'h3_87ff, 18'h3_8fff, 18'h3_9fff};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [3:0] araddr = 4'h0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic cfg_v = 1'b0;
  fpr_cfg_s cfg = '0;
  logic cmd_v = 1'b0;
  fpr_cmd_s cmd = '0;
  logic done;
  logic viol;
  logic flag;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] ep = 8'h7f;
  logic [7:0] ed = 8'h0f;
  logic ef = 1'b0;
  logic ld = 1'b0;
  logic [31:0] rv;
  logic [1:0] rs;
  logic [7:0] b;
  logic [3:0] s;
  logic [17:0] a4 [4];
  fpr_cmd_s k;

  always #5 aclk = ~aclk;

  fpr_flash_protection u_fpr_flash_protection (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .cfg_load_valid(cfg_v),
    .cfg_load(cfg),
    .cmd_valid(cmd_v),
    .cmd(cmd),
    .chk_done(done),
    .chk_violation(viol),
    .protection_violation_flag(flag)
  );

  // ========================================
  // Reference model
  function automatic logic [7:0] pnext(input logic [7:0] c, input logic [7:0] w);
    logic [7:0] n;
    n = {w[7], c[6], w[5], c[4:3], w[2], c[1:0]};
    if (c[5]) n[4:3] = w[4:3];
    if (c[2]) n[1:0] = w[1:0];
    return TR[{c[7], c[5], c[2]}][{n[7], n[5], n[2]}] ? n : c;
  endfunction : pnext

  function automatic logic [7:0] dnext(input logic [7:0] c, input logic [7:0] w);
    if (!(w[7] && !c[7]) && (w[3:0] > c[3:0] || (w[3:0] == c[3:0] && c[7] && !w[7])))
      return {w[7], 3'h0, w[3:0]};
    return c;
  endfunction : dnext

  function automatic logic prot(input logic [7:0] p, input logic [7:0] d, input fpr_cmd_s q);
    logic hit;
    if (q.is_data)
    begin
      if (d[7]) return 1'b0;
      if (q.op == FPR_OP_BLOCK_ERASE) return 1'b1;
      return q.addr >= 18'h0_4400 && q.addr < 18'h0_4400 + 18'(d[3:0] + 1) * 18'h100;
    end
    if (q.op == FPR_OP_BLOCK_ERASE) return {p[7], p[5], p[2]} != 3'h7;
    hit = (!p[5] && q.addr >= HI[p[4:3]]) || (!p[2] && q.addr >= 18'h3_8000 && q.addr <= LO[p[1:0]]);
    return p[7] ? hit : !hit;
  endfunction : prot

  // ========================================
  // Tasks
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_resp

  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t bit got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] t);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'($urandom()), d};
    wstrb <= t;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!(bvalid && bready));
    bready <= 1'b0;
    rs = bresp;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!(rvalid && rready));
    rready <= 1'b0;
    rv = rdata;
    rs = rresp;
  endtask : rd

  task automatic regs();
    rd(FPR_OFS_PGM);
    chk(rv, {24'h0, ep});
    rd(FPR_OFS_DATA);
    chk(rv, {24'h0, ed});
  endtask : regs

  task automatic run_cmd();
    logic e;
    e = prot(ep, ed, k);
    @(posedge aclk);
    cmd_v <= 1'b1;
    cmd <= k;
    @(posedge aclk);
    cmd_v <= 1'b0;
    #1;
    if (e) ef = 1'b1;
    chk_bit(done, 1'b1);
    chk_bit(viol, e);
    chk_bit(flag, ef);
  endtask : run_cmd

  task automatic do_load(input fpr_cfg_s c);
    @(posedge aclk);
    cfg_v <= 1'b1;
    cfg <= c;
    @(posedge aclk);
    cfg_v <= 1'b0;
    if (!ld)
    begin
      ep = c.pgm_dbf ? 8'h7f : c.pgm_byte;
      ed = c.data_dbf ? 8'h0f : c.data_byte & 8'h8f;
    end
    ld = 1'b1;
  endtask : do_load

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    ep = 8'h7f;
    ed = 8'h0f;
    ef = 1'b0;
    ld = 1'b0;
  endtask : do_reset

  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  // ========================================
  // Main sequence
  initial
  begin
    void'($urandom(57533));
    do_reset();
    regs();
    rd(4'hc);
    chk_resp(rs, FPR_RESP_SLVERR);
    chk(rv, 32'h0000_0000);
    wr(4'hc, 8'hff, 4'hf);
    chk_resp(rs, FPR_RESP_SLVERR);
    wr(FPR_OFS_PGM, 8'hff, 4'hf);
    chk_resp(rs, FPR_RESP_OKAY);
    regs();
    $display("test reset done");
    do_load({8'($urandom()), 8'($urandom()), 2'h0});
    regs();
    rd(FPR_OFS_STAT);
    chk(rv, 32'h0000_0002);
    do_load('1);
    regs();
    $display("test load done");
    for (int r = 0; r < 4; r++)
    begin
      do_reset();
      do_load({r == 0 ? 8'hff : 8'($urandom()), r == 0 ? 8'h80 : 8'($urandom()), 2'h0});
      repeat (25)
      begin
        b = 8'($urandom());
        s = ($urandom() % 5 == 0) ? 4'he : 4'hf;
        if ($urandom() % 2)
        begin
          wr(FPR_OFS_PGM, b, s);
          if (s[0]) ep = pnext(ep, b);
        end
        else
        begin
          wr(FPR_OFS_DATA, b, s);
          if (s[0]) ed = dnext(ed, b);
        end
        chk_resp(rs, FPR_RESP_OKAY);
        regs();
        k = {1'($urandom()), fpr_op_e'(2'($urandom() % 3)), 18'h0};
        k.addr = k.is_data ? 18'h0_4000 + 18'($urandom() % 8192) : 18'h3_8000 + 18'($urandom() % 32768);
        run_cmd();
      end
      $display("test random done");
    end
    for (int i = 0; i < 32; i++)
    begin
      do_reset();
      do_load({i[2], 1'b1, i[1], i[4:3], i[0], i[4:3], 4'h0, i[3:0], 2'h0});
      a4 = '{HI[i[4:3]], HI[i[4:3]] - 18'h1, LO[i[4:3]], LO[i[4:3]] + 18'h1};
      for (int j = 0; j < 4; j++)
      begin
        k = {1'b0, FPR_OP_PROGRAM, a4[j]};
        run_cmd();
      end
      k = {1'b1, FPR_OP_SECTOR_ERASE, 18'h0_4400 + 18'(i[3:0] + 1) * 18'h100 - 18'h1};
      run_cmd();
      k.addr = k.addr + 18'h1;
      run_cmd();
      k.op = FPR_OP_BLOCK_ERASE;
      run_cmd();
      k = {1'b0, FPR_OP_BLOCK_ERASE, 18'h3_8000};
      run_cmd();
    end
    $display("test corner done");
    do_reset();
    do_load('1);
    regs();
    k = {1'b1, FPR_OP_PROGRAM, 18'h0_4400};
    run_cmd();
    wr(FPR_OFS_STAT, 8'h01, 4'hf);
    chk_resp(rs, FPR_RESP_OKAY);
    ef = 1'b0;
    rd(FPR_OFS_STAT);
    chk(rv, 32'h0000_0002);
    $display("test fault done");
    wrap_up();
  end
endmodule : fpr_flash_protection_tb
